//--- tb/dso_status_flags_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dso_status_flags_chk #(
  parameter int NUM_TERM = 5
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     arst_n,
  // Wishbone side
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  // Drive side
  input wire dso_pkg::dso_meas_t       meas,
  input wire dso_pkg::dso_state_t      drvState,
  input wire logic                     motorStart,
  input wire logic [NUM_TERM-1:0]      termOut
);
  import dso_pkg::*;
  // ----------------------------------------------------------------
  // Bus handshake, read data and gating of the start output
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_cause: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i >= 8'h48 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_term_readback: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h11
    |-> wb_dat_o[NUM_TERM-1:0] == $past(termOut))
    else $error("terminal readback differs");
  a_start_run: assert property (
    !drvState.runCmd [*2] |=> !motorStart)
    else $error("start without run command");
  a_start_ready: assert property (
    !drvState.precharged [*2] |=> !motorStart)
    else $error("start before precharge");
  a_uv_block: assert property (
    drvState.uvTrip [*3] |=> !motorStart)
    else $error("start during undervoltage");
endmodule
bind dso_status_flags dso_status_flags_chk #(.NUM_TERM(NUM_TERM)) i_chk (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .meas(meas), .drvState(drvState), .motorStart(motorStart),
  .termOut(termOut));
`default_nettype wire

//--- tb/dso_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dso_pkg::*;
  // ----------------------------------------------------------------
  // Signals, instances and bus tasks
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dati = 32'h0000_0000;
  logic [31:0] d;
  logic        answer = 1'b0;
  logic        e;
  wire logic [31:0] dato;
  wire logic        ack;
  wire logic        motorStart;
  wire logic        permit;
  wire logic [4:0]  termOut;
  dso_meas_t   m = '0;
  dso_state_t  st = '0;
  dso_state_t  drvIn;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 88;
  int diff;
  int sb[5] = '{9, 8, 5, 2, 13};
  int fb[5] = '{8, 10, 11, 15, 20};
  logic [15:0] fv[4] = '{16'h1001, 16'h0F9D, 16'h0F9C, 16'h0F9B};
  logic        fe[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  always #2 clk = ~clk;
  // Permit comes from the equipment model, all else from the bench
  always_comb begin
    drvIn = st;
    drvIn.runPermit = permit;
  end
  dso_status_flags #(.NUM_TERM(5), .TICK_CYCLES(10)) i_dut (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati),
    .wb_dat_o(dato), .wb_ack_o(ack), .meas(m), .drvState(drvIn),
    .motorStart(motorStart), .termOut(termOut));
  dso_term_load i_load (.clk(clk), .arst_n(arst_n), .termIn(termOut[0]),
    .answer(answer), .permit(permit));
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ack is sampled on the rising edge; the request drops right after it
  task automatic wbx(logic w, logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= v;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    d = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Arrival expectation: within 2.5 Hz, in 0.01 Hz steps
  function automatic logic expArrive(int df);
    return df <= 250;
  endfunction
  task automatic flag(string nm, int b, logic x);
    wbx(1'b0, 8'h40, 32'h0000_0000);
    chk(nm, d[b], x);
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    m.c1Cur <= 16'h00C8;
    st.precharged <= 1'b1;
    st.ctrlInitDone <= 1'b1;
    wbx(1'b0, 8'h44, 32'h0000_0000);
    chk("termReset", d, 32'h0000_0000);
    wbx(1'b1, 8'h60, 32'h1234_5678);
    wbx(1'b0, 8'h60, 32'h0000_0000);
    chk("unmapped", d, 32'h0000_0000);
    wbx(1'b1, 8'h00, 32'h0000_0001);
    wbx(1'b1, 8'h04, 32'h0000_03E9);
    wbx(1'b1, 8'h08, 32'h0000_000B);
    wbx(1'b1, 8'h0C, 32'h0000_03F3);
    wbx(1'b1, 8'h10, 32'h0000_0004);
    // Random offsets around the tolerance, both edges forced first
    for (int i = 0; i < 16; i++) begin
      diff = (i < 2) ? 250 + i : ($random(seed) & 32'h0000_01FF);
      e = expArrive(diff);
      m.refFreq <= 16'h2000;
      m.outFreq <= ($random(seed) & 1) ? 16'h2000 + diff : 16'h2000 - diff;
      repeat (4) @(posedge clk);
      flag("arrival", 0, e);
      chk("termArrival", termOut[1:0], {~e, e});
      chk("termLocked", termOut[4:2], 3'b000);
    end
    wbx(1'b1, 8'h20, 32'h0000_1000);
    for (int i = 0; i < 4; i++) begin
      m.outFreq <= fv[i];
      repeat (4) @(posedge clk);
      flag("freqDetect", 1, fe[i]);
    end
    flag("c1Loss", 19, 1'b0);
    m.c1Cur <= 16'h00C7;
    repeat (4) @(posedge clk);
    flag("c1Loss", 19, 1'b1);
    for (int k = 0; k < 5; k++) begin
      st[sb[k]] <= 1'b1;
      repeat (4) @(posedge clk);
      flag("stateFlag", fb[k], 1'b1);
      st[sb[k]] <= 1'b0;
    end
    wbx(1'b1, 8'h34, 32'h0001_0000);
    wbx(1'b1, 8'h00, 32'h0000_0037);
    st.runCmd <= 1'b1;
    repeat (6) @(posedge clk);
    flag("runActivated", 18, 1'b1);
    chk("motorStart", motorStart, 1'b0);
    flag("contactor", 7, 1'b1);
    answer <= 1'b1;
    repeat (10) @(posedge clk);
    chk("motorStart", motorStart, 1'b1);
    st.uvTrip <= 1'b1;
    repeat (6) @(posedge clk);
    chk("motorStart", motorStart, 1'b0);
    flag("undervolt", 2, 1'b1);
    st.coastCmd <= 1'b1;
    repeat (4) @(posedge clk);
    flag("contactor", 7, 1'b0);
    wbx(1'b1, 8'h24, 32'h0000_0064);
    wbx(1'b1, 8'h28, 32'h0000_0002);
    m.outCur <= 16'h00C8;
    repeat (8) @(posedge clk);
    flag("overload", 5, 1'b1);
    flag("curDetect", 13, 1'b0);
    repeat (60) @(posedge clk);
    flag("curDetect", 13, 1'b1);
    m.outCur <= 16'h0032;
    repeat (300) @(posedge clk);
    flag("curDetect", 13, 1'b1);
    repeat (1100) @(posedge clk);
    flag("curDetect", 13, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire

//--- tb/dso_term_load.sv
`timescale 1ns/100ps
`default_nettype none
module dso_term_load (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Watched terminal and reply
  input  wire logic termIn,
  input  wire logic answer,
  output logic      permit
);
  logic seenReg;
  // Permit closes two cycles after the flag and is held, since the flag
  // itself drops once motion starts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seenReg <= 1'b0;
      permit  <= 1'b0;
    end else begin
      seenReg <= termIn;
      permit  <= answer & (permit | seenReg);
    end
  end
endmodule
`default_nettype wire

//--- verilog/dso_cfg.svh
`ifndef DSO_CFG_SVH
`define DSO_CFG_SVH
// Operation
// [RL1] Frequency arrival while output and reference differ by at most 2.5 Hz.
// [RL2] Frequency detected above level, cleared below level minus 1 Hz.
// [RL3] Undervoltage below threshold, cleared above it, held during trip.
// [RL4] Run commands are ignored while the undervoltage flag is on.
// [RL5] Output limiting from limiter, hardware limit or auto decel, 100 ms min.
// [RL6] Restart flag in modes 3 to 5 during dip ride-through or restart.
// [RL7] Overload warning above current level; same level drives current detect.
// [RL8] Ready after precharge and init done with no protection active.
// [RL9] Contactor on at run command, off after decel stop; coast/alarm at once.
// [RL10] Auto-reset flag on while an automatic reset sequence runs.
// [RL11] Heat-sink warning at trip minus 5 C, off at minus 8 C, or fan locked.
// [RL12] Service-life flag on end of life of capacitor or fan, or fan locked.
// [RL13] Command-loss flag while analog command lost, off when it resumes.
// [RL14] Overload-prevention flag while active, each pulse at least 100 ms.
// [RL15] Current detected after timer above level, 100 ms min, off below 90%.
// [RL16] PID-active flag when PID not cancelled and run command present.
// [RL17] Low-flow stop flag while stopped by slow-flowrate PID function.
// [RL18] Low torque after timer below torque level, 100 ms minimum.
// [RL19] Remote flag set when operating mode changes from local to remote.
// [RL20] With permit assigned, run command only prepares; permit starts motion.
// [RL21] Current-input loss below 2 mA, cleared at 2 mA or more.
// [RL22] Any-alarm flag while a protective function has put drive in alarm.
// [RL23] Code plus 1000 inverts a terminal; line switching codes cannot invert.
// [RL24] Terminal selectors; unknown codes inactive; widths counted in ms ticks.

// Units: frequency 0.01 Hz, temperature 1 C, input current 0.01 mA
`define DSO_ARRIVE_TOL      16'h00FA
`define DSO_FDT_HYST        16'h0064
`define DSO_HS_WARN_ON      16'h0005
`define DSO_HS_WARN_OFF     16'h0008
`define DSO_C1_MIN          16'h00C8
`define DSO_MIN_ON_MS       16'h0064
`define DSO_INV_OFS         11'h3E8
`define DSO_CLK_MHZ         250
`define DSO_TICK_US         1000
// Register byte offsets
`define DSO_OFS_SEL0        8'h00
`define DSO_OFS_FDTLVL      8'h20
`define DSO_OFS_CURLVL      8'h24
`define DSO_OFS_CURTMR      8'h28
`define DSO_OFS_TRQLVL      8'h2C
`define DSO_OFS_TRQTMR      8'h30
`define DSO_OFS_MODE        8'h34
`define DSO_OFS_UVLVL       8'h38
`define DSO_OFS_HSTRIP      8'h3C
`define DSO_OFS_FLAGS       8'h40
`define DSO_OFS_TERM        8'h44
`endif

//--- verilog/dso_pkg.sv
package dso_pkg;
  // Live drive quantities
  typedef struct packed {
    logic [15:0]        outFreq;
    logic [15:0]        refFreq;
    logic [15:0]        dcVolt;
    logic [15:0]        outCur;
    logic signed [15:0] torque;
    logic [15:0]        hsTemp;
    logic [15:0]        c1Cur;
  } dso_meas_t;
  // Drive state bits
  typedef struct packed {
    logic runCmd;
    logic coastCmd;
    logic motorStopped;
    logic rideThrough;
    logic uvShutdown;
    logic uvTrip;
    logic precharged;
    logic ctrlInitDone;
    logic protActive;
    logic alarmMode;
    logic swCurLimit;
    logic hwCurLimit;
    logic autoDecel;
    logic autoResetBusy;
    logic capLifeEnd;
    logic fanLifeEnd;
    logic fanLocked;
    logic cmdLoss;
    logic overloadPrev;
    logic pidCancel;
    logic pidLowFlowStop;
    logic remoteMode;
    logic runPermit;
  } dso_state_t;
  typedef enum logic [2:0] {
    DSO_IDLE  = 3'b001,
    DSO_CHASE = 3'b010,
    DSO_RESTART = 3'b100
  } dso_dip_t;
endpackage

//--- verilog/dso_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "dso_cfg.svh"
module dso_status_flags #(
  parameter int NUM_TERM    = 5,
  parameter int TICK_CYCLES = `DSO_CLK_MHZ * `DSO_TICK_US
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // Drive quantities and states
  input  wire dso_pkg::dso_meas_t         meas,
  input  wire dso_pkg::dso_state_t        drvState,
  // Run gating and terminals
  output logic                            motorStart,
  output logic [NUM_TERM-1:0]             termOut
);
  import dso_pkg::*;

  // ----------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------
  localparam int FW = 22;
  localparam int F_ARR = 0, F_FDT = 1, F_UV = 2, F_IOL = 3;
  localparam int F_IPF = 4, F_OL = 5, F_RDY = 6, F_AX = 7;
  localparam int F_TRY = 8, F_OH = 9, F_LIFE = 10, F_REF = 11;
  localparam int F_OLP = 12, F_ID = 13, F_PIDC = 14, F_PIDS = 15;
  localparam int F_UTL = 16, F_RMT = 17, F_AX2 = 18, F_C1 = 19;
  localparam int F_ALM = 20, F_RUN = 21;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [15:0] absDiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction

  // Terminal decode; line switching codes and unknowns give zero
  function automatic logic termSel(input logic [10:0] code,
                                   input logic [FW-1:0] f);
    logic [10:0] base;
    logic        inv;
    logic        hit;
    logic        v;
    inv  = code >= `DSO_INV_OFS;                    // see [RL23]
    base = inv ? code - `DSO_INV_OFS : code;
    hit  = 1'b1;
    case (base)
      11'd1:   v = f[F_ARR];
      11'd2:   v = f[F_FDT];
      11'd3:   v = f[F_UV];
      11'd5:   v = f[F_IOL];
      11'd6:   v = f[F_IPF];
      11'd7:   v = f[F_OL];
      11'd10:  v = f[F_RDY];
      11'd15:  v = f[F_AX];
      11'd26:  v = f[F_TRY];
      11'd28:  v = f[F_OH];
      11'd30:  v = f[F_LIFE];
      11'd33:  v = f[F_REF];
      11'd36:  v = f[F_OLP];
      11'd37:  v = f[F_ID];
      11'd43:  v = f[F_PIDC];
      11'd44:  v = f[F_PIDS];
      11'd45:  v = f[F_UTL];
      11'd54:  v = f[F_RMT];
      11'd55:  v = f[F_AX2];
      11'd59:  v = f[F_C1];
      11'd99:  v = f[F_ALM];
      default: begin
        v   = 1'b0;
        hit = 1'b0;                                 // see [RL24]
      end
    endcase
    termSel = hit & (v ^ inv);
  endfunction

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic [10:0]   selReg [NUM_TERM];
  logic [15:0]   fdtLvlReg;
  logic [15:0]   curLvlReg;
  logic [19:0]   curTmrReg;
  logic signed [15:0] trqLvlReg;
  logic [19:0]   trqTmrReg;
  logic [2:0]    restartModeReg;
  logic          hwLimEnReg;
  logic [3:0]    autoDecelModeReg;
  logic          permitAssignedReg;
  logic [15:0]   uvLvlReg;
  logic [15:0]   hsTripReg;
  logic          ackReg;
  logic [31:0]   rdataReg;

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  wire logic        busReq  = wb_cyc_i & wb_stb_i & ~ackReg;
  wire logic [7:0]  wordAdr = {wb_adr_i[7:2], 2'b00};
  wire logic        selFull = &wb_sel_i;
  wire logic [5:0]  selIdx  = wb_adr_i[7:2];
  wire logic        selHit  = wordAdr < `DSO_OFS_SEL0 + 8'(4 * NUM_TERM);
  wire logic [FW-1:0] flags;
  wire logic [31:0] termWord = 32'(termOut);
  logic      [31:0] rdataNext;

  // Read mux; unmapped words read as zero
  always_comb begin
    rdataNext = 32'h0000_0000;
    if (selHit)
      rdataNext = {21'h00_0000, selReg[selIdx[2:0]]};
    else
      case (wordAdr)
        `DSO_OFS_FDTLVL: rdataNext = {16'h0000, fdtLvlReg};
        `DSO_OFS_CURLVL: rdataNext = {16'h0000, curLvlReg};
        `DSO_OFS_CURTMR: rdataNext = {12'h000, curTmrReg};
        `DSO_OFS_TRQLVL: rdataNext = {16'h0000, trqLvlReg};
        `DSO_OFS_TRQTMR: rdataNext = {12'h000, trqTmrReg};
        `DSO_OFS_MODE:   rdataNext = {15'h0000, permitAssignedReg,
                                      4'h0, autoDecelModeReg, 3'h0,
                                      hwLimEnReg, 1'b0, restartModeReg};
        `DSO_OFS_UVLVL:  rdataNext = {16'h0000, uvLvlReg};
        `DSO_OFS_HSTRIP: rdataNext = {16'h0000, hsTripReg};
        `DSO_OFS_FLAGS:  rdataNext = 32'(flags);
        `DSO_OFS_TERM:   rdataNext = termWord;
        default:         rdataNext = 32'h0000_0000;
      endcase
  end

  // One wait state: ack the cycle after the request, drop next
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ackReg   <= 1'b0;
      rdataReg <= 32'h0000_0000;
    end else begin
      ackReg   <= busReq;
      rdataReg <= rdataNext;
    end
  end
  assign wb_ack_o = ackReg;
  assign wb_dat_o = rdataReg;

  // Writes land on the ack edge; partial byte enables are ignored
  wire logic cfgWr = wb_cyc_i & wb_stb_i & wb_we_i & ackReg & selFull;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_TERM; i++)
        selReg[i] <= 11'h000;
    end else if (cfgWr && selHit) begin
      selReg[selIdx[2:0]] <= wb_dat_i[10:0];     // see [RL24]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fdtLvlReg <= 16'h0000;
      curLvlReg <= 16'h0000;
      curTmrReg <= 20'h0_0000;
      trqLvlReg <= 16'h0000;
      trqTmrReg <= 20'h0_0000;
      uvLvlReg  <= 16'h0000;
      hsTripReg <= 16'h0000;
    end else if (cfgWr) begin
      case (wordAdr)
        `DSO_OFS_FDTLVL: fdtLvlReg <= wb_dat_i[15:0];
        `DSO_OFS_CURLVL: curLvlReg <= wb_dat_i[15:0];
        `DSO_OFS_CURTMR: curTmrReg <= wb_dat_i[19:0];
        `DSO_OFS_TRQLVL: trqLvlReg <= wb_dat_i[15:0];
        `DSO_OFS_TRQTMR: trqTmrReg <= wb_dat_i[19:0];
        `DSO_OFS_UVLVL:  uvLvlReg  <= wb_dat_i[15:0];
        `DSO_OFS_HSTRIP: hsTripReg <= wb_dat_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restartModeReg    <= 3'h0;
      hwLimEnReg        <= 1'b0;
      autoDecelModeReg  <= 4'h0;
      permitAssignedReg <= 1'b0;
    end else if (cfgWr && wordAdr == `DSO_OFS_MODE) begin
      restartModeReg    <= wb_dat_i[2:0];
      hwLimEnReg        <= wb_dat_i[4];
      autoDecelModeReg  <= wb_dat_i[11:8];
      permitAssignedReg <= wb_dat_i[16];
    end
  end

  // ----------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------
  logic [31:0] tickCntReg;
  wire logic   msTick = tickCntReg == 32'(TICK_CYCLES - 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      tickCntReg <= 32'h0000_0000;
    else
      tickCntReg <= msTick ? 32'h0000_0000 : tickCntReg + 32'h0000_0001;
  end

  // ----------------------------------------------------------
  // Comparator flags
  // ----------------------------------------------------------
  wire logic arrive = absDiff(meas.outFreq, meas.refFreq)
                      <= `DSO_ARRIVE_TOL;              // see [RL1]
  wire logic fdtOn  = meas.outFreq > fdtLvlReg;
  wire logic fdtOff = 17'(meas.outFreq) + 17'(`DSO_FDT_HYST)
                      < 17'(fdtLvlReg);
  wire logic curOver = (curLvlReg != 16'h0000)
                       && meas.outCur > curLvlReg;     // see [RL7]
  wire logic curLow  = 20'(meas.outCur) * 20'd10
                       < 20'(curLvlReg) * 20'd9;       // see [RL15]
  wire logic trqLow  = meas.torque < trqLvlReg;
  wire logic hsOn  = 17'(meas.hsTemp) + 17'(`DSO_HS_WARN_ON)
                     > 17'(hsTripReg);
  wire logic hsOff = 17'(meas.hsTemp) + 17'(`DSO_HS_WARN_OFF)
                     <= 17'(hsTripReg);

  logic fdtReg;
  logic uvReg;
  logic hsReg;
  // Hysteresis latches; between the two thresholds they hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fdtReg <= 1'b0;
      uvReg  <= 1'b0;
      hsReg  <= 1'b0;
    end else begin
      if (fdtOn)
        fdtReg <= 1'b1;                                // see [RL2]
      else if (fdtOff)
        fdtReg <= 1'b0;
      if (meas.dcVolt < uvLvlReg)
        uvReg <= 1'b1;                                 // see [RL3]
      else if (meas.dcVolt > uvLvlReg)
        uvReg <= 1'b0;
      if (hsOn)
        hsReg <= 1'b1;                                 // see [RL11]
      else if (hsOff)
        hsReg <= 1'b0;
    end
  end
  wire logic uvFlag = uvReg | drvState.uvTrip;         // see [RL3]

  // ----------------------------------------------------------
  // Persistence timers for current and torque detection
  // ----------------------------------------------------------
  logic [19:0] curTimeReg;
  logic [19:0] trqTimeReg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      curTimeReg <= 20'h0_0000;
      trqTimeReg <= 20'h0_0000;
    end else begin
      if (!curOver)
        curTimeReg <= 20'h0_0000;
      else if (msTick && curTimeReg <= curTmrReg)
        curTimeReg <= curTimeReg + 20'h0_0001;
      if (!trqLow)
        trqTimeReg <= 20'h0_0000;
      else if (msTick && trqTimeReg <= trqTmrReg)
        trqTimeReg <= trqTimeReg + 20'h0_0001;
    end
  end
  wire logic curTrig = curTimeReg > curTmrReg;         // see [RL15]
  wire logic trqTrig = trqTimeReg > trqTmrReg;         // see [RL18]

  // ----------------------------------------------------------
  // Minimum on-width stretchers: OUTPUT_LIMITING, OVERLOAD_PREVENT_ACTIVE, ID, low torque
  // ----------------------------------------------------------
  localparam int NS = 4;
  wire logic limAct = drvState.swCurLimit
                    | (drvState.hwCurLimit & hwLimEnReg)
                    | (drvState.autoDecel
                       & autoDecelModeReg == 4'h3);    // see [RL5]
  logic [NS-1:0] stTrig;
  logic [NS-1:0] stHoldOff;
  logic [NS-1:0] stOutReg;
  logic [15:0]   stCntReg [NS];
  assign stTrig    = {trqTrig, curTrig, drvState.overloadPrev, limAct};
  // ID holds past its trigger until current drops under 90%
  assign stHoldOff = {~trqTrig, curLow, ~drvState.overloadPrev, ~limAct};

  // Flag falls only when its cause is gone and 100 ms have passed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stOutReg <= '0;
      for (int i = 0; i < NS; i++)
        stCntReg[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (!stOutReg[i]) begin
          stOutReg[i] <= stTrig[i];                    // see [RL14]
          stCntReg[i] <= 16'h0000;
        end else begin
          if (msTick && stCntReg[i] < `DSO_MIN_ON_MS)
            stCntReg[i] <= stCntReg[i] + 16'h0001;   // see [RL24]
          if (stHoldOff[i] && stCntReg[i] >= `DSO_MIN_ON_MS)
            stOutReg[i] <= 1'b0;                       // see [RL5]
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Power dip restart tracking
  // ----------------------------------------------------------
  wire logic ipfEn = restartModeReg >= 3'h3
                   && restartModeReg <= 3'h5;
  dso_dip_t dipReg;
  dso_dip_t dipNext;
  // Shutdown latches the flag until output regains the reference
  always_comb begin
    dipNext = dipReg;
    case (dipReg)
      DSO_IDLE:
        if (ipfEn && drvState.uvShutdown)
          dipNext = DSO_RESTART;
        else if (ipfEn && drvState.rideThrough)
          dipNext = DSO_CHASE;
      DSO_CHASE:
        if (drvState.uvShutdown)
          dipNext = DSO_RESTART;
        else if (!drvState.rideThrough || !ipfEn)
          dipNext = DSO_IDLE;
      DSO_RESTART:
        if (!ipfEn || (arrive && !drvState.motorStopped
                       && !drvState.uvShutdown))
          dipNext = DSO_IDLE;
      default: dipNext = DSO_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      dipReg <= DSO_IDLE;
    else
      dipReg <= dipNext;
  end
  wire logic ipfFlag = dipReg != DSO_IDLE;             // see [RL6]

  // ----------------------------------------------------------
  // Run sequencing, contactor and remote edge
  // ----------------------------------------------------------
  wire logic runOk   = drvState.runCmd & ~uvFlag;      // see [RL4]
  wire logic rdyFlag = drvState.precharged & drvState.ctrlInitDone
                     & ~drvState.protActive;           // see [RL8]
  // Without a permit input the run command starts the motor directly
  wire logic startOk = runOk & rdyFlag
                     & (drvState.runPermit | ~permitAssignedReg);
  logic axReg;
  logic runReg;
  logic remPrevReg;
  logic rmtReg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      axReg      <= 1'b0;
      runReg     <= 1'b0;
      remPrevReg <= 1'b0;
      rmtReg     <= 1'b0;
    end else begin
      if (drvState.coastCmd || drvState.alarmMode)
        axReg <= 1'b0;                                 // see [RL9]
      else if (runOk)
        axReg <= 1'b1;
      else if (drvState.motorStopped)
        axReg <= 1'b0;
      runReg     <= startOk;                           // see [RL20]
      remPrevReg <= drvState.remoteMode;
      if (drvState.remoteMode && !remPrevReg)
        rmtReg <= 1'b1;                                // see [RL19]
      else if (!drvState.remoteMode)
        rmtReg <= 1'b0;
    end
  end
  assign motorStart = runReg;

  // ----------------------------------------------------------
  // Flag vector
  // ----------------------------------------------------------
  assign flags[F_ARR]  = arrive;
  assign flags[F_FDT]  = fdtReg;
  assign flags[F_UV]   = uvFlag;
  assign flags[F_IOL]  = stOutReg[0];
  assign flags[F_IPF]  = ipfFlag;
  assign flags[F_OL]   = curOver;
  assign flags[F_RDY]  = rdyFlag;
  assign flags[F_AX]   = axReg;
  assign flags[F_TRY]  = drvState.autoResetBusy;      // see [RL10]
  assign flags[F_OH]   = hsReg | drvState.fanLocked;  // see [RL11]
  assign flags[F_LIFE] = drvState.capLifeEnd
                       | drvState.fanLifeEnd
                       | drvState.fanLocked;          // see [RL12]
  assign flags[F_REF]  = drvState.cmdLoss;            // see [RL13]
  assign flags[F_OLP]  = stOutReg[1];
  assign flags[F_ID]   = stOutReg[2];
  assign flags[F_PIDC] = ~drvState.pidCancel
                       & drvState.runCmd;             // see [RL16]
  assign flags[F_PIDS] = drvState.pidLowFlowStop
                       & ~drvState.pidCancel;         // see [RL17]
  assign flags[F_UTL]  = stOutReg[3];
  assign flags[F_RMT]  = rmtReg;
  assign flags[F_AX2]  = permitAssignedReg & runOk
                       & ~drvState.runPermit;         // see [RL20]
  assign flags[F_C1]   = meas.c1Cur < `DSO_C1_MIN;   // see [RL21]
  assign flags[F_ALM]  = drvState.alarmMode;          // see [RL22]
  assign flags[F_RUN]  = runReg;

  // ----------------------------------------------------------
  // Output terminals, registered
  // ----------------------------------------------------------
  logic [NUM_TERM-1:0] termNext;
  logic [NUM_TERM-1:0] termReg;
  always_comb begin
    for (int i = 0; i < NUM_TERM; i++)
      termNext[i] = termSel(selReg[i], flags);        // see [RL23]
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      termReg <= '0;
    else
      termReg <= termNext;
  end
  assign termOut = termReg;

endmodule
`default_nettype wire
